//--- dv/cfr_far_node.sv
// Far-side model: a CAN node on one remappable pin and the FIFO attempt flags
`timescale 1ns/1ps
`default_nettype none
module cfr_far_node #(
    parameter int NUM_PINS = 256
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Bus node placement and level
    input wire logic [7:0] node_pin,
    input wire logic node_level,
    output logic [NUM_PINS-1:0] pins,
    // FIFO attempt flag events
    input wire logic [7:0] flag_set,
    input wire logic [7:0] flag_clr,
    output logic [7:0] flags
);
    // Pins without a node sit at the pulled-up recessive level
    always_comb begin
        pins = '1;
        pins[node_pin] = node_level;
    end
    // A flag goes away only when its own FIFO clears it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            flags <= 8'h00;
        end else begin
            flags <= (flags | flag_set) & ~flag_clr;
        end
    end
endmodule : cfr_far_node
`default_nettype wire

//--- dv/testbench.sv
// Self-checking testbench for the filter routing block
`timescale 1ns/1ps
`default_nettype none
`include "cfr_defines.svh"
module testbench;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic filter_hit = 1'b0;
    logic [3:0] filter_index = 4'h0;
    logic store_valid, store_reject, can_rx, irq;
    logic [4:0] store_object;
    logic [7:0] flags, flag_set = 8'h00, flag_clr = 8'h00;
    logic [7:0] node_pin = 8'h00;
    logic node_level = 1'b1;
    logic [255:0] pins;
    int err_total = 0;
    int n_checks = 0;
    always #10 clock = ~clock;
    cfr_far_node #(.NUM_PINS(256)) far (.clock(clock), .resetn(resetn),
        .node_pin(node_pin), .node_level(node_level), .pins(pins),
        .flag_set(flag_set), .flag_clr(flag_clr), .flags(flags));
    cfr_top #(.NUM_PINS(256)) dut (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .filter_hit(filter_hit),
        .filter_index(filter_index), .store_valid(store_valid),
        .store_object(store_object), .store_reject(store_reject),
        .tx_attempt_pending(flags), .remappable_pin(pins),
        .can_receive_input(can_rx), .irq(irq));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd
    task automatic hit(input logic [3:0] i, input logic [1:0] vr,
                       input logic [4:0] obj);
        @(posedge clock);
        filter_hit <= 1'b1;
        filter_index <= i;
        @(posedge clock);
        filter_hit <= 1'b0;
        #1 check({store_valid, store_reject}, vr);
        check(store_object, obj);
    endtask : hit
    task automatic t_reset;
        for (int a = 0; a < 10; a++) rd(a[3:0], 16'h0000);
        check(can_rx, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_filters;
        for (int x = 0; x < 4; x++) begin
            wr(x[3:0], 16'hFFFF);
            rd(x[3:0], 16'h9F9F);
            wr(x[3:0], 16'h0000);
        end
        $display("test filter registers done");
    endtask : t_filters
    task automatic t_route;
        wr(4'h0, 16'h8300);
        hit(4'h1, 2'b10, 5'h03);
        hit(4'h0, 2'b01, 5'h03);
        wr(4'h1, 16'h0087);
        hit(4'h4, 2'b10, 5'h07);
        hit(4'h5, 2'b01, 5'h07);
        wr(4'h2, 16'h8880);
        hit(4'h9, 2'b01, 5'h07);
        hit(4'h8, 2'b01, 5'h07);
        wr(4'h3, 16'h8180);
        hit(4'hC, 2'b01, 5'h07);
        hit(4'hD, 2'b10, 5'h01);
        hit(4'h2, 2'b01, 5'h01);
        $display("test routing done");
    endtask : t_route
    task automatic t_txat;
        @(posedge clock);
        flag_set <= 8'hA5;
        @(posedge clock);
        flag_set <= 8'h00;
        repeat (3) @(posedge clock);
        rd(4'h4, 16'h00A5);
        rd(4'h5, 16'h0000);
        wr(4'h4, 16'hFFFF);
        wr(4'h5, 16'hFFFF);
        rd(4'h4, 16'h00A5);
        rd(4'h5, 16'h0000);
        @(posedge clock);
        flag_clr <= 8'h01;
        @(posedge clock);
        flag_clr <= 8'h00;
        repeat (3) @(posedge clock);
        rd(4'h4, 16'h00A4);
        $display("test attempt flags done");
    endtask : t_txat
    task automatic t_pin;
        wr(4'h6, 16'hFF2A);
        rd(4'h6, 16'h002A);
        @(posedge clock);
        node_pin <= 8'h2A;
        node_level <= 1'b0;
        repeat (8) @(posedge clock);
        #1 check(can_rx, 1'b0);
        @(posedge clock);
        node_pin <= 8'h2B;
        repeat (8) @(posedge clock);
        #1 check(can_rx, 1'b1);
        $display("test pin select done");
    endtask : t_pin
    task automatic t_irq;
        wr(4'h7, 16'h0007);
        rd(4'h7, 16'h0000);
        wr(4'h8, 16'h0001);
        hit(4'h1, 2'b10, 5'h03);
        repeat (2) @(posedge clock);
        #1 check(irq, 1'b1);
        wr(4'h8, 16'h0002);
        repeat (2) @(posedge clock);
        #1 check(irq, 1'b0);
        hit(4'h0, 2'b01, 5'h03);
        repeat (2) @(posedge clock);
        #1 check(irq, 1'b1);
        rd(4'h7, 16'h0003);
        wr(4'h7, 16'h0002);
        repeat (2) @(posedge clock);
        #1 check(irq, 1'b0);
        rd(4'h7, 16'h0001);
        wr(4'h8, 16'h0004);
        @(posedge clock);
        flag_clr <= 8'hFF;
        @(posedge clock);
        flag_clr <= 8'h00;
        flag_set <= 8'h08;
        @(posedge clock);
        flag_set <= 8'h00;
        repeat (4) @(posedge clock);
        #1 check(irq, 1'b1);
        rd(4'h4, 16'h0008);
        rd(4'h7, 16'h0005);
        $display("test interrupt done");
    endtask : t_irq
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        #200000;
        err_total++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_filters();
        t_route();
        t_txat();
        t_pin();
        t_irq();
        complete_run();
    end
endmodule : testbench
`default_nettype wire

//--- include/cfr_defines.svh
// Register offsets, field positions and reset values for filter routing
`ifndef CFR_DEFINES_SVH
`define CFR_DEFINES_SVH
`define CFR_ADDR_W 4
`define CFR_OFS_FLT0 4'h0
`define CFR_OFS_FLT1 4'h1
`define CFR_OFS_FLT2 4'h2
`define CFR_OFS_FLT3 4'h3
`define CFR_OFS_TXAT_LO 4'h4
`define CFR_OFS_TXAT_HI 4'h5
`define CFR_OFS_PINSEL 4'h6
`define CFR_OFS_IRQ_STAT 4'h7
`define CFR_OFS_IRQ_MASK 4'h8
`define CFR_FLT_RW_MASK 16'h9F9F
`define CFR_PINSEL_MASK 16'h00FF
`define CFR_PTR_MIN 5'h01
`define CFR_PTR_MAX 5'h07
`define CFR_EN_LO 7
`define CFR_EN_HI 15
`define CFR_PTR_LO_LSB 0
`define CFR_PTR_HI_LSB 8
`define CFR_RESET16 16'h0000
`define CFR_IRQ_ROUTED 0
`define CFR_IRQ_REJECT 1
`define CFR_IRQ_TXAT 2
`define CFR_IRQ_W 3
`endif

//--- include/cfr_pkg.sv
// Types shared by the filter routing block
package cfr_pkg;
    typedef logic [15:0] cfr_word_t;
    typedef logic [4:0] cfr_ptr_t;
    typedef enum logic [1:0] {
        CFR_IDLE = 2'b00,
        CFR_ROUTE = 2'b01,
        CFR_DROP = 2'b10
    } cfr_route_e;
endpackage : cfr_pkg

//--- verilog/cfr_sync3.sv
// Three-stage pin synchroniser, change taken once stages 2 and 3 agree
`timescale 1ns/1ps
`default_nettype none
module cfr_sync3 (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Pin and synchronised level
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level <= 1'b1;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end
endmodule : cfr_sync3
`default_nettype wire

//--- verilog/cfr_top.sv
// CAN filter routing, transmit attempt flag summary and receive pin select
//
// What this block does
// - An enabled hit on filter 0,1,4,5,8,9,12 or 13 stores into object 1 to 7 by pointer, else nowhere.
// - Bits 14 to 13 and 6 to 5 of each filter register read as zero.
// - Bits 7 to 0 of the low attempt status are read-only pending flags.
// - Flag 0 is the transmit queue and flags 1 to 7 the transmit FIFOs.
// - The high attempt status and bits 15 to 8 of the low one read zero.
// - The receive pin number is byte 0 of pin select; byte 1 reads zero.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "cfr_defines.svh"
module cfr_top
    import cfr_pkg::*;
#(
    parameter int NUM_PINS = 256
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire logic [`CFR_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // Filter hits from the acceptance logic
    input wire logic filter_hit,
    input wire logic [3:0] filter_index,
    // Routing result
    output logic store_valid,
    output logic [4:0] store_object,
    output logic store_reject,
    // Transmit attempt flags kept by the FIFOs
    input wire logic [7:0] tx_attempt_pending,
    // Remappable pins and selected receive input
    input wire logic [NUM_PINS-1:0] remappable_pin,
    output logic can_receive_input,
    // Interrupt
    output logic irq
);
    cfr_word_t flt_q [4];
    logic [7:0] can_rx_pin_number_q;
    logic [7:0] txat_q;
    logic [`CFR_IRQ_W-1:0] irq_stat_q;
    logic [`CFR_IRQ_W-1:0] irq_mask_q;
    logic [`CFR_IRQ_W-1:0] irq_set;
    cfr_route_e route_q;
    logic txat_prev_q;

    // Selected filter fields
    cfr_word_t sel_reg;
    logic sel_en;
    cfr_ptr_t sel_ptr;
    logic sel_ok;
    logic rx_sync;

    // Assertions below share this clock and reset
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);

    always_comb begin
        sel_reg = flt_q[filter_index[3:2]];
        if (filter_index[0]) begin
            sel_en = sel_reg[`CFR_EN_HI];
            sel_ptr = sel_reg[`CFR_PTR_HI_LSB +: 5];
        end else begin
            sel_en = sel_reg[`CFR_EN_LO];
            sel_ptr = sel_reg[`CFR_PTR_LO_LSB +: 5];
        end
        // Only filters 0,1,4,5,8,9,12,13 exist here
        sel_ok = sel_en && !filter_index[1]
            && sel_ptr >= `CFR_PTR_MIN && sel_ptr <= `CFR_PTR_MAX;
    end

    // Filter control registers, unimplemented bits never stored
    always_ff @(posedge clock) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                flt_q[i] <= `CFR_RESET16;
            end
        end else if (reg_write && reg_addr <= `CFR_OFS_FLT3) begin
            flt_q[reg_addr[1:0]] <= reg_wdata & `CFR_FLT_RW_MASK;
        end
    end

    // Receive pin select
    always_ff @(posedge clock) begin
        if (!resetn) begin
            can_rx_pin_number_q <= '0;
        end else if (reg_write && reg_addr == `CFR_OFS_PINSEL) begin
            can_rx_pin_number_q <= reg_wdata[7:0];
        end
    end

    // Routing decision, one result pulse per hit
    always_ff @(posedge clock) begin
        if (!resetn) begin
            route_q <= CFR_IDLE;
            store_valid <= 1'b0;
            store_reject <= 1'b0;
            store_object <= '0;
        end else begin
            store_valid <= filter_hit && sel_ok;
            store_reject <= filter_hit && !sel_ok;
            if (filter_hit && sel_ok) begin
                store_object <= sel_ptr;
            end
            unique case (route_q)
                CFR_IDLE,
                CFR_ROUTE,
                CFR_DROP: begin
                    if (!filter_hit) begin
                        route_q <= CFR_IDLE;
                    end else if (sel_ok) begin
                        route_q <= CFR_ROUTE;
                    end else begin
                        route_q <= CFR_DROP;
                    end
                end
                default: route_q <= CFR_IDLE;
            endcase
        end
    end

    // Attempt flags mirror the FIFO flags; nothing here clears them
    always_ff @(posedge clock) begin
        if (!resetn) begin
            txat_q <= '0;
            txat_prev_q <= 1'b0;
        end else begin
            txat_q <= tx_attempt_pending;
            txat_prev_q <= |txat_q;
        end
    end

    // Pin input synchronised before use
    cfr_sync3 u_rx_sync (
        .clock(clock),
        .resetn(resetn),
        .pin(remappable_pin[can_rx_pin_number_q]),
        .level(rx_sync)
    );

    always_ff @(posedge clock) begin
        if (!resetn) begin
            can_receive_input <= 1'b1;
        end else begin
            can_receive_input <= rx_sync;
        end
    end

    // Interrupt events
    always_comb begin
        irq_set = '0;
        irq_set[`CFR_IRQ_ROUTED] = store_valid;
        irq_set[`CFR_IRQ_REJECT] = store_reject;
        irq_set[`CFR_IRQ_TXAT] = (|txat_q) && !txat_prev_q;
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_stat_q <= '0;
        end else if (reg_write && reg_addr == `CFR_OFS_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~reg_wdata[`CFR_IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq_mask_q <= '0;
        end else if (reg_write && reg_addr == `CFR_OFS_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[`CFR_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat_q | irq_set) & irq_mask_q);
        end
    end

    // Read data in the cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= `CFR_RESET16;
        end else if (reg_read) begin
            unique case (reg_addr)
                `CFR_OFS_FLT0,
                `CFR_OFS_FLT1,
                `CFR_OFS_FLT2,
                `CFR_OFS_FLT3: reg_rdata <= flt_q[reg_addr[1:0]]
                    & `CFR_FLT_RW_MASK;
                `CFR_OFS_TXAT_LO: reg_rdata <= {8'h00, txat_q};
                `CFR_OFS_TXAT_HI: reg_rdata <= `CFR_RESET16;
                `CFR_OFS_PINSEL: reg_rdata <= {8'h00, can_rx_pin_number_q};
                `CFR_OFS_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_q};
                `CFR_OFS_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_q};
                default: reg_rdata <= `CFR_RESET16;
            endcase
        end else begin
            reg_rdata <= `CFR_RESET16;
        end
    end

    // Routing: one result pulse per hit, objects 1 to 7 only
    a_route_valid: assert property (
        filter_hit && sel_ok
        |=> store_valid && store_object == $past(sel_ptr))
        else $error("enabled hit not routed to its object");

    a_route_range: assert property (
        store_valid
        |-> store_object >= `CFR_PTR_MIN && store_object <= `CFR_PTR_MAX)
        else $error("reserved object selected");

    a_reserved_ptr: assert property (
        filter_hit && (sel_ptr < `CFR_PTR_MIN || sel_ptr > `CFR_PTR_MAX)
        |=> !store_valid && store_reject)
        else $error("reserved pointer accepted a message");

    a_disabled_drop: assert property (
        filter_hit && !sel_en
        |=> !store_valid && store_reject)
        else $error("disabled filter accepted a message");

    a_high_enable: assert property (
        filter_hit && filter_index[0]
            && !flt_q[filter_index[3:2]][`CFR_EN_HI]
        |=> !store_valid)
        else $error("cleared high enable accepted a message");

    a_low_enable: assert property (
        filter_hit && !filter_index[0]
            && !flt_q[filter_index[3:2]][`CFR_EN_LO]
        |=> !store_valid)
        else $error("cleared low enable accepted a message");

    a_absent_filter: assert property (
        filter_hit && filter_index[1]
        |=> !store_valid && store_reject)
        else $error("absent filter accepted a message");

    a_result_single: assert property (
        !(store_valid && store_reject))
        else $error("hit both accepted and rejected");

    a_no_hit_quiet: assert property (
        !filter_hit |=> !store_valid && !store_reject)
        else $error("result pulse without a hit");

    a_object_hold: assert property (
        !(filter_hit && sel_ok) |=> $stable(store_object))
        else $error("object changed without an accepted hit");

    a_route_state: assert property (
        store_valid == (route_q == CFR_ROUTE)
            && store_reject == (route_q == CFR_DROP))
        else $error("routing state and result pulses disagree");

    // Register read view
    a_flt_reserved: assert property (
        reg_read && reg_addr <= `CFR_OFS_FLT3
        |=> (reg_rdata & ~`CFR_FLT_RW_MASK) == `CFR_RESET16)
        else $error("unimplemented filter bits read nonzero");

    a_flt_stored: assert property (
        ((flt_q[0] | flt_q[1] | flt_q[2] | flt_q[3])
            & ~`CFR_FLT_RW_MASK) == `CFR_RESET16)
        else $error("unimplemented filter bits stored");

    a_txat_mirror: assert property (
        reg_read && reg_addr == `CFR_OFS_TXAT_LO
        |=> reg_rdata[7:0] == $past(txat_q))
        else $error("attempt flags misreported");

    a_txq_pos0: assert property (
        $past(resetn) |-> txat_q[0] == $past(tx_attempt_pending[0]))
        else $error("queue flag not at position 0");

    a_txat_ro: assert property (
        reg_write |=> txat_q == $past(tx_attempt_pending))
        else $error("write disturbed attempt flags");

    a_txat_high: assert property (
        reg_read && (reg_addr == `CFR_OFS_TXAT_LO
            || reg_addr == `CFR_OFS_TXAT_HI)
        |=> reg_rdata[15:8] == 8'h00)
        else $error("unimplemented attempt bits nonzero");

    a_txat_hi_zero: assert property (
        reg_read && reg_addr == `CFR_OFS_TXAT_HI
        |=> reg_rdata == `CFR_RESET16)
        else $error("high attempt status nonzero");

    a_pinsel_upper: assert property (
        reg_read && reg_addr == `CFR_OFS_PINSEL
        |=> reg_rdata[15:8] == 8'h00)
        else $error("pin select upper byte nonzero");

    a_pinsel_hold: assert property (
        !(reg_write && reg_addr == `CFR_OFS_PINSEL)
        |=> $stable(can_rx_pin_number_q))
        else $error("pin number changed without a write");

    a_rx_follow: assert property (
        $past(resetn) |-> can_receive_input == $past(rx_sync))
        else $error("receive input not fed from selected pin");

    // Interrupt status and level
    a_irq_sticky: assert property (
        store_valid |=> irq_stat_q[`CFR_IRQ_ROUTED])
        else $error("routed event lost");

    a_irq_reject: assert property (
        store_reject |=> irq_stat_q[`CFR_IRQ_REJECT])
        else $error("rejected event lost");

    a_irq_level: assert property (
        $past(resetn) |-> irq == |(($past(irq_stat_q) | $past(irq_set))
            & $past(irq_mask_q)))
        else $error("interrupt level does not follow status");

    a_rdata_idle: assert property (
        !reg_read |=> reg_rdata == `CFR_RESET16)
        else $error("read data outside the read answer cycle");

    // Main scenarios
    c_routed: cover property (store_valid);
    c_rejected: cover property (store_reject);
    c_irq: cover property (irq);
    c_txat_event: cover property (irq_set[`CFR_IRQ_TXAT]);
    c_pin_low: cover property (!can_receive_input);
endmodule : cfr_top
`default_nettype wire
